//--- verilog/scan_port_defs.vh
// constants for the boundary-scan test access port
`ifndef SCAN_PORT_DEFS_VH
`define SCAN_PORT_DEFS_VH

// instruction register
`define IR_W            2
`define IR_EXTEST       2'h0
`define IR_SAMPLE_A     2'h1
`define IR_SAMPLE_B     2'h2
`define IR_BYPASS       2'h3
`define IR_CAPTURE_VAL  2'h1

// boundary chain length, cells 0 to 167
`define BSR_LEN         168

// one-hot controller states
`define ST_W            16
`define ST_RESET        16'h0001
`define ST_IDLE         16'h0002
`define ST_SEL_DR       16'h0004
`define ST_CAP_DR       16'h0008
`define ST_SH_DR        16'h0010
`define ST_EX1_DR       16'h0020
`define ST_PAU_DR       16'h0040
`define ST_EX2_DR       16'h0080
`define ST_UPD_DR       16'h0100
`define ST_SEL_IR       16'h0200
`define ST_CAP_IR       16'h0400
`define ST_SH_IR        16'h0800
`define ST_EX1_IR       16'h1000
`define ST_PAU_IR       16'h2000
`define ST_EX2_IR       16'h4000
`define ST_UPD_IR       16'h8000

// synchroniser reset levels: clock low, pulled-up pins high
`define SYNC_RST_VAL    4'hE

`endif

//--- verilog/pin_sync.v
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter          W       = 4,
    parameter [W-1:0]  RST_VAL = {W{1'b0}}
) (
    input  wire         clk_i,
    input  wire         rst_n_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);

    reg [W-1:0] meta_q;

    // first stage feeds only the second stage
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= RST_VAL;
            q_o    <= RST_VAL;
        end
        else
        begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule // pin_sync

`default_nettype wire

//--- verilog/tap_ctrl.v
// sixteen-state test access port controller
`timescale 1ns/1ps
`default_nettype none
`include "scan_port_defs.vh"

module tap_ctrl (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire             trst_i,
    input  wire             step_i,
    input  wire             tms_i,
    output reg  [`ST_W-1:0] state_o
);

    function [`ST_W-1:0] next_state;
        input [`ST_W-1:0] s;
        input             m;
        begin
            case (s)
                `ST_RESET:  next_state = m ? `ST_RESET  : `ST_IDLE;
                `ST_IDLE:   next_state = m ? `ST_SEL_DR : `ST_IDLE;
                `ST_SEL_DR: next_state = m ? `ST_SEL_IR : `ST_CAP_DR;
                `ST_CAP_DR: next_state = m ? `ST_EX1_DR : `ST_SH_DR;
                `ST_SH_DR:  next_state = m ? `ST_EX1_DR : `ST_SH_DR;
                `ST_EX1_DR: next_state = m ? `ST_UPD_DR : `ST_PAU_DR;
                `ST_PAU_DR: next_state = m ? `ST_EX2_DR : `ST_PAU_DR;
                `ST_EX2_DR: next_state = m ? `ST_UPD_DR : `ST_SH_DR;
                `ST_UPD_DR: next_state = m ? `ST_SEL_DR : `ST_IDLE;
                `ST_SEL_IR: next_state = m ? `ST_RESET  : `ST_CAP_IR;
                `ST_CAP_IR: next_state = m ? `ST_EX1_IR : `ST_SH_IR;
                `ST_SH_IR:  next_state = m ? `ST_EX1_IR : `ST_SH_IR;
                `ST_EX1_IR: next_state = m ? `ST_UPD_IR : `ST_PAU_IR;
                `ST_PAU_IR: next_state = m ? `ST_EX2_IR : `ST_PAU_IR;
                `ST_EX2_IR: next_state = m ? `ST_UPD_IR : `ST_SH_IR;
                `ST_UPD_IR: next_state = m ? `ST_SEL_DR : `ST_IDLE;
                // an illegal code falls back to the safe reset state
                default:    next_state = `ST_RESET;
            endcase
        end
    endfunction

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_o <= `ST_RESET;
        else if (trst_i)
            state_o <= `ST_RESET;
        else if (step_i)
            state_o <= next_state(state_o, tms_i);
    end

endmodule // tap_ctrl

`default_nettype wire

//--- verilog/scan_port.v
// boundary-scan test access port: instruction, bypass and boundary chain
//
// Operation
// - test mode select is sampled at each test clock rise and steps the controller
// - test data input is captured at each test clock rise
// - test data output changes on the test clock fall
// - test data output floats whenever no shift is under way
// - mode select, data input and test reset read high when undriven
// - test reset forces controller and instruction register to reset
// - test clock is only sampled on the system clock, no system clock is disturbed
// - boundary shifting runs alongside normal core operation untouched
// - input bits go to instruction or selected data register by state
// - output shows instruction or selected data register by state
// - instruction register is two bits, shifted in shift-instruction state, loaded in update-instruction state
// - instruction picks the active data register and serial path
// - 11 bypass, 10 and 01 sample/preload, 00 extest
// - only two data registers: boundary chain and bypass
// - bypass is one flip-flop, a single-bit delay path
// - boundary chain holds cells 0 through 167
// - cell 0 leaves the output first in a boundary scan
// - three-state control cells enable their driver when holding one
`timescale 1ns/1ps
`default_nettype none
`include "scan_port_defs.vh"

module scan_port #(
    parameter                BSR_LEN   = `BSR_LEN,
    // marks which boundary cells are three-state controls
    parameter [BSR_LEN-1:0]  CTRL_MASK = {BSR_LEN{1'b0}}
) (
    input  wire                clk_i,
    input  wire                rst_n_i,
    input  wire                tck_i,
    input  wire                tms_i,
    input  wire                tdi_i,
    input  wire                trst_n_i,
    input  wire [BSR_LEN-1:0]  pin_capture_i,
    output reg                 tdo_o,
    output reg                 tdo_oe_n_o,
    output reg  [`IR_W-1:0]    instr_o,
    output reg                 extest_o,
    output reg  [BSR_LEN-1:0]  bsr_update_o,
    output reg  [BSR_LEN-1:0]  drive_en_o,
    output wire [`ST_W-1:0]    tap_state_o
);

    // boundary chain is chosen by every code but bypass
    function bsr_sel;
        input [`IR_W-1:0] code;
        begin
            case (code)
                `IR_BYPASS:   bsr_sel = 1'b0;
                `IR_SAMPLE_A: bsr_sel = 1'b1;
                `IR_SAMPLE_B: bsr_sel = 1'b1;
                `IR_EXTEST:   bsr_sel = 1'b1;
                default:      bsr_sel = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // pin inputs
    // ------------------------------------------------------------------
    wire [3:0] raw_pins;
    wire [3:0] sync_pins;

    wire       tck_s;
    wire       tms_s;
    wire       tdi_s;
    wire       trst_n_s;

    reg        tck_prev_q;
    wire       tck_rise;
    wire       tck_fall;
    wire       trst_act;

    assign raw_pins = {tdi_i, tms_i, trst_n_i, tck_i};

    // pulled-up pins sit high out of reset until really sampled
    pin_sync #(
        .W       (4),
        .RST_VAL (`SYNC_RST_VAL)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (raw_pins),
        .q_o     (sync_pins)
    );

    assign tck_s    = sync_pins[0];
    assign trst_n_s = sync_pins[1];
    assign tms_s    = sync_pins[2];
    assign tdi_s    = sync_pins[3];

    // test clock is only sampled, never used as a clock net
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tck_prev_q <= 1'b0;
        else
            tck_prev_q <= tck_s;
    end

    // all four pins share one synchroniser, so they stay aligned
    assign tck_rise = tck_s & ~tck_prev_q;
    assign tck_fall = ~tck_s & tck_prev_q;
    assign trst_act = ~trst_n_s;

    // ------------------------------------------------------------------
    // controller
    // ------------------------------------------------------------------
    wire [`ST_W-1:0] state;

    tap_ctrl u_tap (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .trst_i  (trst_act),
        .step_i  (tck_rise),
        .tms_i   (tms_s),
        .state_o (state)
    );

    assign tap_state_o = state;

    wire in_reset;
    wire in_cap_dr;
    wire in_sh_dr;
    wire in_upd_dr;
    wire in_cap_ir;
    wire in_sh_ir;
    wire in_upd_ir;

    assign in_reset  = (state == `ST_RESET);
    assign in_cap_dr = (state == `ST_CAP_DR);
    assign in_sh_dr  = (state == `ST_SH_DR);
    assign in_upd_dr = (state == `ST_UPD_DR);
    assign in_cap_ir = (state == `ST_CAP_IR);
    assign in_sh_ir  = (state == `ST_SH_IR);
    assign in_upd_ir = (state == `ST_UPD_IR);

    // ------------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------------
    reg  [`IR_W-1:0] ir_shift_q;
    reg  [`IR_W-1:0] ir_shift_d;
    wire             sel_bsr;

    always @*
    begin
        ir_shift_d = ir_shift_q;
        if (in_cap_ir)
            ir_shift_d = `IR_CAPTURE_VAL;
        else if (in_sh_ir)
            ir_shift_d = {tdi_s, ir_shift_q[`IR_W-1:1]};
    end

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ir_shift_q <= `IR_BYPASS;
        else if (trst_act)
            ir_shift_q <= `IR_BYPASS;
        else if (tck_rise)
            ir_shift_q <= ir_shift_d;
    end

    // no identification register, so reset lands on bypass
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            instr_o <= `IR_BYPASS;
        else if (trst_act)
            instr_o <= `IR_BYPASS;
        // reset state forces bypass at once, not at the next test clock
        else if (in_reset)
            instr_o <= `IR_BYPASS;
        else if (tck_rise && in_upd_ir)
            instr_o <= ir_shift_q;
    end

    assign sel_bsr = bsr_sel(instr_o);

    // ------------------------------------------------------------------
    // data registers: bypass stage and boundary chain
    // ------------------------------------------------------------------
    reg               bypass_q;
    reg [BSR_LEN-1:0] bsr_shift_q;
    reg [BSR_LEN-1:0] bsr_shift_d;

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            bypass_q <= 1'b0;
        else if (tck_rise && !sel_bsr)
        begin
            if (in_cap_dr)
                bypass_q <= 1'b0;
            else if (in_sh_dr)
                bypass_q <= tdi_s;
        end
    end

    // cell 0 sits at the output end, new bits enter at the top
    always @*
    begin
        bsr_shift_d = bsr_shift_q;
        if (in_cap_dr)
            bsr_shift_d = pin_capture_i;
        else if (in_sh_dr)
            bsr_shift_d = {tdi_s, bsr_shift_q[BSR_LEN-1:1]};
    end

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            bsr_shift_q <= {BSR_LEN{1'b0}};
        else if (tck_rise && sel_bsr)
            bsr_shift_q <= bsr_shift_d;
    end

    // update stage keeps the pins steady while the chain shifts
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            bsr_update_o <= {BSR_LEN{1'b0}};
        else if (trst_act)
            bsr_update_o <= {BSR_LEN{1'b0}};
        else if (tck_rise && in_upd_dr && sel_bsr)
            bsr_update_o <= bsr_shift_q;
    end

    // only extest hands the pins to the chain; sample leaves core alone
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            extest_o <= 1'b0;
        else
            extest_o <= (instr_o == `IR_EXTEST);
    end

    // ------------------------------------------------------------------
    // three-state control cells, active high
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < BSR_LEN; g = g + 1)
        begin : g_drv
            always @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    drive_en_o[g] <= 1'b0;
                else
                    drive_en_o[g] <= CTRL_MASK[g] & bsr_update_o[g];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // serial output, changed on the falling test clock edge
    // ------------------------------------------------------------------
    reg tdo_d;
    reg shifting;

    always @*
    begin
        shifting = in_sh_ir | in_sh_dr;
        if (in_sh_ir)
            tdo_d = ir_shift_q[0];
        else if (sel_bsr)
            tdo_d = bsr_shift_q[0];
        else
            tdo_d = bypass_q;
    end

    // falling edge gives the tester half a period of setup
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tdo_o      <= 1'b0;
            tdo_oe_n_o <= 1'b1;
        end
        else if (trst_act)
        begin
            tdo_o      <= 1'b0;
            tdo_oe_n_o <= 1'b1;
        end
        else if (tck_fall)
        begin
            tdo_o      <= shifting ? tdo_d : 1'b0;
            tdo_oe_n_o <= ~shifting;
        end
    end

endmodule // scan_port

`default_nettype wire

//--- sim/scan_tester.sv
// boundary-scan tester model driving the test port pins
`timescale 1ns/1ps
`default_nettype none
module scan_tester (
    input  wire logic clk_i,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_n_i,
    output var  logic tck_o,
    output var  logic tms_o,
    output var  logic tdi_o
);
    logic last_q = 1'b0;
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end
    // one test clock of 8 system clocks; pins move with the fall, 4 clk
    // before the rise, so the port's 2 clk synchroniser sees them settled
    task automatic step(input logic m, input logic d, output logic o);
    begin
        tms_o = m;
        tdi_o = d;
        tck_o = 1'b0;
        repeat (4) @(negedge clk_i);
        // no pull on the output: a floating line gives no stale bit
        o = tdo_oe_n_i ? ~last_q : tdo_i;
        last_q = o;
        tck_o = 1'b1;
        repeat (4) @(negedge clk_i);
    end
    endtask
endmodule // scan_tester
`default_nettype wire

//--- sim/scan_port_checker.sv
// assertions on the boundary-scan test port outputs
`timescale 1ns/1ps
`default_nettype none
`include "scan_port_defs.vh"
module scan_port_checker #(
    parameter int                 BSR_LEN   = `BSR_LEN,
    parameter logic [BSR_LEN-1:0] CTRL_MASK = {BSR_LEN{1'b0}}
) (
    input wire logic               clk_i,
    input wire logic               rst_n_i,
    input wire logic               tck_i,
    input wire logic               trst_n_i,
    input wire logic               tdo_o,
    input wire logic               tdo_oe_n_o,
    input wire logic [1:0]         instr_o,
    input wire logic               extest_o,
    input wire logic [BSR_LEN-1:0] bsr_update_o,
    input wire logic [BSR_LEN-1:0] drive_en_o,
    input wire logic [15:0]        tap_state_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // states in which nothing may be driven out
    localparam logic [15:0] QUIET = ~(`ST_SH_DR | `ST_EX1_DR | `ST_SH_IR
                                      | `ST_EX1_IR | `ST_RESET);
    // pin edge: 2 sync flops, 1 edge detect, 1 more to be sampled here
    sequence s_tck_fell;
        $past(tck_i, 4) && !$past(tck_i, 3);
    endsequence
    sequence s_tck_rose;
        !$past(tck_i, 4) && $past(tck_i, 3);
    endsequence
    sequence s_trst_seen;
        !$past(trst_n_i, 2) || !$past(trst_n_i, 3);
    endsequence
    sequence s_trst_held;
        !trst_n_i [*4];
    endsequence
    sequence s_reset_twice;
        tap_state_o == `ST_RESET ##1 tap_state_o == `ST_RESET;
    endsequence
    property p_quiet;
        |(tap_state_o & QUIET) |-> tdo_oe_n_o;
    endproperty
    property p_tdo_fall;
        $changed(tdo_o) |-> s_tck_fell or s_trst_seen;
    endproperty
    property p_oe_fall;
        $changed(tdo_oe_n_o) |-> s_tck_fell or s_trst_seen;
    endproperty
    property p_step_rise;
        $changed(tap_state_o) |-> s_tck_rose or s_trst_seen;
    endproperty
    property p_instr_src;
        $changed(instr_o) |-> $past(tap_state_o) == `ST_UPD_IR
                              || tap_state_o == `ST_RESET;
    endproperty
    property p_update_src;
        $changed(bsr_update_o) |-> $past(tap_state_o) == `ST_UPD_DR
            || tap_state_o == `ST_UPD_DR || tap_state_o == `ST_RESET;
    endproperty
    property p_extest;
        extest_o == ($past(instr_o) == `IR_EXTEST);
    endproperty
    property p_drive_en;
        drive_en_o == (CTRL_MASK & $past(bsr_update_o));
    endproperty
    property p_trst;
        s_trst_held |-> tap_state_o == `ST_RESET && tdo_oe_n_o
            && instr_o == `IR_BYPASS && bsr_update_o == '0;
    endproperty
    property p_reset_bypass;
        s_reset_twice |-> instr_o == `IR_BYPASS && $onehot(tap_state_o);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("output enabled outside a shift");
    a_tdo_fall: assert property (p_tdo_fall)
        else $error("data out moved away from a test clock fall");
    a_oe_fall: assert property (p_oe_fall)
        else $error("output enable moved away from a test clock fall");
    a_step_rise: assert property (p_step_rise)
        else $error("controller stepped without a test clock rise");
    a_instr_src: assert property (p_instr_src)
        else $error("instruction changed outside update or reset");
    a_update_src: assert property (p_update_src)
        else $error("update stage changed outside update or reset");
    a_extest: assert property (p_extest)
        else $error("extest flag does not follow code 00");
    a_drive_en: assert property (p_drive_en)
        else $error("drive enable not mask and update stage");
    a_trst: assert property (p_trst)
        else $error("test reset did not clear the scan logic");
    a_reset_bypass: assert property (p_reset_bypass)
        else $error("reset state without bypass instruction");
endmodule // scan_port_checker
bind scan_port scan_port_checker #(.BSR_LEN(BSR_LEN), .CTRL_MASK(CTRL_MASK))
    chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .tck_i(tck_i),
         .trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
         .instr_o(instr_o), .extest_o(extest_o),
         .bsr_update_o(bsr_update_o), .drive_en_o(drive_en_o),
         .tap_state_o(tap_state_o));
`default_nettype wire

//--- sim/scan_port_tb.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
`include "scan_port_defs.vh"
module scan_port_tb;
    localparam logic [167:0] MASK  = {42{4'h9}};
    localparam logic [167:0] CAP_A = {42{4'h1}};
    localparam logic [167:0] IN_A  = {42{4'h3}};
    logic         clk_i, rst_n_i, trst_n_i, tck, tms, tdi, tdo, oe_n, ext;
    logic [167:0] pins, upd, den;
    logic [1:0]   instr;
    logic [15:0]  st;
    int           error_cnt = 0;
    int           comparisons = 0;
    int           cyc = 0;
    scan_port #(.BSR_LEN(168), .CTRL_MASK(MASK)) uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .trst_n_i(trst_n_i), .pin_capture_i(pins),
        .tdo_o(tdo), .tdo_oe_n_o(oe_n), .instr_o(instr), .extest_o(ext),
        .bsr_update_o(upd), .drive_en_o(den), .tap_state_o(st));
    scan_tester tst (.clk_i(clk_i), .tdo_i(tdo), .tdo_oe_n_i(oe_n),
                     .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // whole run needs about 3600 clocks
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 12000)
        begin
            error_cnt++;
            test_done();
        end
    end
    task automatic test_done();
    begin
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    task automatic check(input string name, input logic [167:0] seen,
                         input logic [167:0] exp);
    begin
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    // from idle, one scan of n bits, back to idle; out bits in shift order
    task automatic scan(input logic ir, input int n,
                        input logic [167:0] din, output logic [167:0] dout);
        logic o;
    begin
        dout = '0;
        tst.step(1'b1, 1'b1, o);
        if (ir)
            tst.step(1'b1, 1'b1, o);
        tst.step(1'b0, 1'b1, o);
        tst.step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++)
        begin
            tst.step(i == n - 1, din[i], o);
            dout[i] = o;
            check("shift enable", oe_n, 1'b0);
        end
        tst.step(1'b1, 1'b1, o);
        tst.step(1'b0, 1'b1, o);
        tst.step(1'b0, 1'b1, o);
        check("idle enable", oe_n, 1'b1);
    end
    endtask
    task automatic load_ir(input logic [1:0] c);
        logic [167:0] d;
    begin
        scan(1'b1, 2, {166'h0, c}, d);
        check("ir capture", d[1:0], `IR_CAPTURE_VAL);
        check("instr", instr, c);
        check("extest", ext, c == `IR_EXTEST);
    end
    endtask
    task automatic t_reset();
        logic o;
    begin
        check("reset state", st, `ST_RESET);
        check("reset instr", instr, `IR_BYPASS);
        check("reset enable", oe_n, 1'b1);
        tst.step(1'b0, 1'b1, o);
        check("idle state", st, `ST_IDLE);
        for (int c = 0; c < 4; c++)
            load_ir(c[1:0]);
    end
    endtask
    task automatic t_bypass();
        logic [167:0] d;
    begin
        load_ir(`IR_BYPASS);
        scan(1'b0, 9, 168'h00A5, d);
        check("bypass out", d[8:0], 9'h14A);
    end
    endtask
    task automatic t_boundary(input logic [1:0] c, input logic [167:0] cap,
                              input logic [167:0] din);
        logic [167:0] d;
    begin
        load_ir(c);
        pins = cap;
        scan(1'b0, 168, din, d);
        check("chain out", d, cap);
        check("update", upd, din);
        check("drive en", den, MASK & din);
    end
    endtask
    task automatic t_resets();
        logic o;
    begin
        trst_n_i = 1'b0;
        repeat (6) @(negedge clk_i);
        check("trst state", st, `ST_RESET);
        check("trst instr", instr, `IR_BYPASS);
        check("trst update", upd, 168'h0);
        trst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        tst.step(1'b0, 1'b1, o);
        load_ir(`IR_EXTEST);
        repeat (5) tst.step(1'b1, 1'b1, o);
        check("tms reset", st, `ST_RESET);
        check("tms instr", instr, `IR_BYPASS);
        tst.step(1'b0, 1'b1, o);
    end
    endtask
    initial
    begin
        rst_n_i = 1'b0;
        trst_n_i = 1'b1;
        pins = '0;
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        t_reset();
        t_bypass();
        t_boundary(`IR_SAMPLE_B, CAP_A, IN_A);
        t_boundary(`IR_EXTEST, ~CAP_A, ~IN_A);
        t_resets();
        test_done();
    end
endmodule // scan_port_tb
`default_nettype wire
